// >>> bench/spi_pin_and_select_modes_tb_top.sv
// Self-checking bench for the serial port pins, select modes and byte paths
`timescale 1ns/10ps
`include "sps_consts.svh"
module spi_pin_and_select_modes_tb_top
   import sps_pkg::*;
   ;
   logic sys_clk, reset, cfg_write, clear_done, clear_fault, tx_valid, rx_ready;
   sps_cfg_t cfg_data;
   logic [7:0] tx_data, rx_data, r;
   logic [1:0] select_mode_field;
   logic master_enable_bit, port_enable_bit, transfer_done_flag, mode_fault_flag, tx_ready;
   logic rx_valid, mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, miso_line;
   logic slave_select_n_out, slave_select_n_oe, select_pin_mapped;
   logic p_miso, p_sck, p_mosi, p_sel_n;
   int fails = 0;
   int n_tests = 0;
   // Undriven slave-out line shows the inverse of the peer's mosi line
   assign miso_line = miso_oe ? miso_out : !p_mosi;
   sps_port i_dut (.sys_clk(sys_clk), .reset(reset), .cfg_write(cfg_write),
      .cfg_data(cfg_data), .select_mode_field(select_mode_field),
      .master_enable_bit(master_enable_bit), .port_enable_bit(port_enable_bit),
      .transfer_done_flag(transfer_done_flag), .mode_fault_flag(mode_fault_flag),
      .clear_done(clear_done), .clear_fault(clear_fault), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .mosi_in(p_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
      .miso_in(p_miso), .miso_out(miso_out), .miso_oe(miso_oe), .sck_in(p_sck),
      .sck_out(sck_out), .sck_oe(sck_oe), .slave_select_n_in(p_sel_n),
      .slave_select_n_out(slave_select_n_out), .slave_select_n_oe(slave_select_n_oe),
      .select_pin_mapped(select_pin_mapped));
   sps_peer i_peer (.m_sck(sck_out), .m_mosi(mosi_out), .s_miso(miso_line),
      .p_miso(p_miso), .p_sck(p_sck), .p_mosi(p_mosi), .p_sel_n(p_sel_n));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Config takes two edges to reach the pin enables, so wait past both
   task cfg(input logic [1:0] m, input logic ms, input logic pe);
      @(negedge sys_clk);
      cfg_write = 1'b1;
      cfg_data = '{m, ms, pe};
      @(negedge sys_clk);
      cfg_write = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask
   task wait_done;
      int k;
      @(negedge sys_clk);
      for (k = 0; k < 300 && transfer_done_flag !== 1'b1; k++) @(negedge sys_clk);
      chk(transfer_done_flag, 8'h01, "done flag");
      clear_done = 1'b1;
      @(negedge sys_clk);
      clear_done = 1'b0;
   endtask
   task pop(input logic [7:0] exp);
      int k;
      for (k = 0; k < 50 && rx_valid !== 1'b1; k++) @(negedge sys_clk);
      chk(rx_valid, 8'h01, "rx valid");
      chk(rx_data, exp, "rx byte");
      rx_ready = 1'b1;
      @(negedge sys_clk);
      rx_ready = 1'b0;
   endtask
   task push(input logic [7:0] b);
      while (tx_ready !== 1'b1) @(negedge sys_clk);
      tx_valid = 1'b1;
      tx_data = b;
      @(negedge sys_clk);
      tx_valid = 1'b0;
   endtask
   task t_reset;
      chk({mosi_oe, sck_oe, miso_oe, slave_select_n_oe}, 8'h00, "oe after reset");
      chk({select_mode_field, master_enable_bit, port_enable_bit},
         {`SPS_RST_MODE, `SPS_RST_MASTER, `SPS_RST_PORT}, "cfg after reset");
      chk({transfer_done_flag, mode_fault_flag, rx_valid, tx_ready}, 8'h01, "flags");
   endtask
   task t_master3;
      cfg(2'h0, 1'b1, 1'b1);
      chk({mosi_oe, sck_oe, miso_oe, slave_select_n_oe, select_pin_mapped}, 8'h18, "m3");
      i_peer.load(8'h3C);
      push(8'hA5);
      wait_done;
      chk(i_peer.got, 8'hA5, "master out bits");
      pop(8'h3C);
   endtask
   task t_sel_out;
      logic [1:0] m;
      for (m = 2'h2; m != 2'h0; m++) begin
         cfg(m, 1'b1, 1'b1);
         chk({slave_select_n_oe, slave_select_n_out, select_pin_mapped}, {1'b1, m[0], 1'b1}, "sel");
      end
   endtask
   task t_fault;
      int k;
      cfg(2'h1, 1'b1, 1'b1);
      chk(mode_fault_flag, 8'h00, "no fault yet");
      i_peer.set_sel(1'b0);
      for (k = 0; k < 10 && mode_fault_flag !== 1'b1; k++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
      chk({mode_fault_flag, master_enable_bit, port_enable_bit, sck_oe, mosi_oe}, 8'h10, "mf");
      i_peer.set_sel(1'b1);
      clear_fault = 1'b1;
      @(negedge sys_clk);
      clear_fault = 1'b0;
      @(negedge sys_clk);
      chk(mode_fault_flag, 8'h00, "fault cleared");
   endtask
   task t_slave4;
      cfg(2'h1, 1'b0, 1'b1);
      chk({mosi_oe, sck_oe, miso_oe, slave_select_n_oe, select_pin_mapped}, 8'h01, "s4");
      push(8'h96);
      i_peer.xfer(8'hFF, 1'b0, r);
      repeat (20) @(negedge sys_clk);
      chk({transfer_done_flag, rx_valid}, 8'h00, "unselected clocks");
      i_peer.xfer(8'h5A, 1'b1, r);
      wait_done;
      chk(r, 8'h96, "slave out byte");
      pop(8'h5A);
   endtask
   // Receiver stalls through three bytes: two are kept, the third is dropped
   task t_slave3;
      cfg(2'h0, 1'b0, 1'b1);
      chk(miso_oe, 8'h01, "3-wire slave drives");
      push(8'hC3);
      i_peer.xfer(8'h11, 1'b0, r);
      chk(r, 8'hC3, "3-wire slave out");
      repeat (8) @(negedge sys_clk);
      i_peer.xfer(8'h22, 1'b0, r);
      repeat (8) @(negedge sys_clk);
      i_peer.xfer(8'h33, 1'b0, r);
      repeat (8) @(negedge sys_clk);
      pop(8'h11);
      pop(8'h22);
      @(negedge sys_clk);
      chk(rx_valid, 8'h00, "buffer drained");
      cfg(2'h0, 1'b0, 1'b0);
      chk(miso_oe, 8'h00, "disabled floats");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      cfg_write = 1'b0;
      cfg_data = '0;
      clear_done = 1'b0;
      clear_fault = 1'b0;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      rx_ready = 1'b0;
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      repeat (2) @(negedge sys_clk);
      t_reset;
      t_master3;
      t_sel_out;
      t_fault;
      t_slave4;
      t_slave3;
      end_sim;
   end
   // Watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #2000000;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule

// >>> bench/sps_peer.sv
// Far-side model: an outside slave for master runs, an outside master for slave runs
`timescale 1ns/10ps
module sps_peer (
   // Lines coming from the port
   input wire logic m_sck,
   input wire logic m_mosi,
   input wire logic s_miso,
   // Lines going to the port
   output logic p_miso,
   output logic p_sck,
   output logic p_mosi,
   output logic p_sel_n
);
   logic [7:0] sreg = 8'h00;
   logic [7:0] got = 8'h00;
   initial begin
      p_sck = 1'b0;
      p_mosi = 1'b0;
      p_sel_n = 1'b1;
   end
   // Slave side: first bit stands before the first rise, later bits follow each fall
   assign p_miso = sreg[7];
   always @(posedge m_sck) got <= {got[6:0], m_mosi};
   always @(negedge m_sck) sreg <= {sreg[6:0], 1'b0};
   // Sole slave on the wire while the port runs three-wire
   task load(input logic [7:0] b);
      sreg = b;
   endtask
   task set_sel(input logic v);
      p_sel_n = v;
   endtask
   // Master side: link clock runs only inside a frame, 32 ns period
   task xfer(input logic [7:0] b, input logic sel, output logic [7:0] r);
      integer i;
      p_sel_n = !sel;
      #100;
      for (i = 7; i >= 0; i--) begin
         p_mosi = b[i];
         #16 r = {r[6:0], s_miso};
         p_sck = 1'b1;
         #16 p_sck = 1'b0;
      end
      #100;
      p_sel_n = 1'b1;
      p_mosi = !p_mosi; // A released line must not keep showing the last bit
   endtask
endmodule

// >>> design/sps_buffer.sv
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/10ps
`include "sps_consts.svh"
module sps_buffer
   import sps_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [`SPS_WORD_W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [`SPS_WORD_W-1:0] out_data
);
   logic [`SPS_WORD_W-1:0] slot [0:1];
   logic [1:0] count;
   logic wr_ptr;
   logic rd_ptr;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Flags come straight from the occupancy count
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[rd_ptr];

   // Pointers and occupancy
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count <= 2'h0;
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + {1'h0, push} - {1'h0, pop};
      end
   end

   // Storage needs no reset; out_valid guards it
   always_ff @(posedge sys_clk) begin
      if (push) slot[wr_ptr] <= in_data;
   end
endmodule

// >>> design/sps_consts.svh
// Constants for the serial port: select modes, widths and serial clock timing
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// Select mode field encodings
`define SPS_MODE_3WIRE 2'h0
`define SPS_MODE_4WIRE_IN 2'h1
`define SPS_HI_BIT 1
`define SPS_LO_BIT 0

// Data word layout
`define SPS_WORD_W 8
`define SPS_MSB 7
`define SPS_LAST_BIT 3'h7

// Reset values of the control bits
`define SPS_RST_MODE 2'h1
`define SPS_RST_MASTER 1'h0
`define SPS_RST_PORT 1'h0

// Timing: system clock period and least serial clock half period, in ns
`define SPS_SYS_CLK_NS 40
`define SPS_SCK_HALF_NS 120
`define SPS_SCK_HALF_CYC ((`SPS_SCK_HALF_NS + `SPS_SYS_CLK_NS - 1) / `SPS_SYS_CLK_NS)

`endif

// >>> design/sps_pkg.sv
// Types shared by the serial port design files
package sps_pkg;
   // Master sequencer states
   typedef enum logic [1:0] {
      SPS_IDLE,
      SPS_LOW,
      SPS_HIGH
   } sps_state_t;

   // Software configuration written in one strobe
   typedef struct packed {
      logic [1:0] select_mode_field;
      logic master_enable_bit;
      logic port_enable_bit;
   } sps_cfg_t;

   // Two-signal drive view (out and oe) of a two-way pin
   typedef struct packed {
      logic out;
      logic oe;
   } sps_pin_drive_t;
endpackage

// >>> design/sps_port.sv
// Full-duplex serial port, master or slave, with three select-pin modes
`timescale 1ns/10ps
`include "sps_consts.svh"
module sps_port
   import sps_pkg::*;
(
   // System clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Configuration strobe and current control bits
   input wire logic cfg_write,
   input wire sps_cfg_t cfg_data,
   output logic [1:0] select_mode_field,
   output logic master_enable_bit,
   output logic port_enable_bit,
   // Sticky flags and their clear strobes
   output logic transfer_done_flag,
   output logic mode_fault_flag,
   input wire logic clear_done,
   input wire logic clear_fault,
   // Transmit byte handshake
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [`SPS_WORD_W-1:0] tx_data,
   // Receive byte handshake
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [`SPS_WORD_W-1:0] rx_data,
   // Serial data pins
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   // Serial clock pin; the input is the link clock
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   // Slave select pin
   input wire logic slave_select_n_in,
   output logic slave_select_n_out,
   output logic slave_select_n_oe,
   output logic select_pin_mapped
);
   localparam int HALF_CYC = `SPS_SCK_HALF_CYC;

   // Master-side state
   sps_state_t state;
   logic [`SPS_WORD_W-1:0] shift_reg;
   logic [2:0] bit_cnt;
   logic [1:0] half_cnt;
   logic tx_full;
   logic [`SPS_WORD_W-1:0] tx_word;
   logic master_push;
   // Pin synchronisers
   logic miso_s1, miso_s2;
   logic ss_s1, ss_s2, ss_s3;
   // Link-side state
   logic [`SPS_WORD_W-1:0] link_shift;
   logic [2:0] link_cnt;
   logic [`SPS_WORD_W-1:0] link_hold;
   logic link_tgl;
   logic tgl_s1, tgl_s2, tgl_s3;
   // Buffer wiring
   logic buf_in_ready;

   function automatic logic is_mode(input logic [1:0] m, input logic [1:0] code);
      is_mode = (m == code);
   endfunction

   // Mode decode
   wire mode_3wire = is_mode(select_mode_field, `SPS_MODE_3WIRE);
   wire mode_4in = is_mode(select_mode_field, `SPS_MODE_4WIRE_IN);
   wire mode_out = select_mode_field[`SPS_HI_BIT];
   wire act_master = port_enable_bit && master_enable_bit;
   wire act_slave = port_enable_bit && !master_enable_bit;
   // A 3-wire slave is always selected; mode 01 selects on a low pin
   wire selected = mode_3wire || (mode_4in && !ss_s2);
   wire ss_fall = ss_s3 && !ss_s2;
   wire fault = act_master && mode_4in && ss_fall;
   wire slave_done = tgl_s2 ^ tgl_s3;
   wire half_end = (half_cnt == 2'(HALF_CYC - 1));
   wire last_bit = (bit_cnt == `SPS_LAST_BIT);
   // Back-pressure: a master byte starts only while the buffer has room
   wire start = act_master && (state == SPS_IDLE) && tx_full && buf_in_ready;
   wire master_end = (state == SPS_HIGH) && half_end && last_bit;
   wire next_done_evt = master_end || (act_slave && slave_done);
   wire [`SPS_WORD_W-1:0] next_shift = {shift_reg[`SPS_MSB-1:0], miso_s2};
   wire [`SPS_WORD_W-1:0] push_data = master_push ? shift_reg : link_hold;
   wire push_valid = master_push || (act_slave && slave_done);

   // Pin synchronisers: first stage is read only by the second
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         miso_s1 <= 1'h0;
         miso_s2 <= 1'h0;
         ss_s1 <= 1'h1;
         ss_s2 <= 1'h1;
         ss_s3 <= 1'h1;
         tgl_s1 <= 1'h0;
         tgl_s2 <= 1'h0;
         tgl_s3 <= 1'h0;
      end else begin
         miso_s1 <= miso_in;
         miso_s2 <= miso_s1;
         ss_s1 <= slave_select_n_in;
         ss_s2 <= ss_s1;
         ss_s3 <= ss_s2;
         tgl_s1 <= link_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
      end
   end

   // Control bits; a mode fault overrides a write in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         select_mode_field <= `SPS_RST_MODE;
         master_enable_bit <= `SPS_RST_MASTER;
         port_enable_bit <= `SPS_RST_PORT;
      end else if (fault) begin
         master_enable_bit <= 1'h0;
         port_enable_bit <= 1'h0;
      end else if (cfg_write) begin
         select_mode_field <= cfg_data.select_mode_field;
         master_enable_bit <= cfg_data.master_enable_bit;
         port_enable_bit <= cfg_data.port_enable_bit;
      end
   end

   // Sticky flags: a set in the clear cycle wins
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         transfer_done_flag <= 1'h0;
         mode_fault_flag <= 1'h0;
      end else begin
         transfer_done_flag <= next_done_evt || (transfer_done_flag && !clear_done);
         mode_fault_flag <= fault || (mode_fault_flag && !clear_fault);
      end
   end

   // Transmit holding register; emptied when a master byte starts or a slave byte completes.
   // Ready is a flop of its own so that the port output has no gate before it.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_full <= 1'h0;
         tx_ready <= 1'h1;
         tx_word <= 8'h00;
      end else if (tx_valid && !tx_full) begin
         tx_full <= 1'h1;
         tx_ready <= 1'h0;
         tx_word <= tx_data;
      end else if (start || (act_slave && slave_done)) begin
         tx_full <= 1'h0;
         tx_ready <= 1'h1;
      end
   end

   // Master sequencer: clock low half, clock high half, sample at the fall
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= SPS_IDLE;
         half_cnt <= 2'h0;
         bit_cnt <= 3'h0;
         shift_reg <= 8'h00;
         master_push <= 1'h0;
      end else begin
         master_push <= master_end;
         case (state)
            SPS_IDLE: begin
               half_cnt <= 2'h0;
               bit_cnt <= 3'h0;
               if (start) begin
                  shift_reg <= tx_word;
                  state <= SPS_LOW;
               end
            end
            SPS_LOW: begin
               half_cnt <= half_end ? 2'h0 : half_cnt + 2'h1;
               if (!act_master) state <= SPS_IDLE;
               else if (half_end) state <= SPS_HIGH;
            end
            SPS_HIGH: begin
               half_cnt <= half_end ? 2'h0 : half_cnt + 2'h1;
               if (half_end) begin
                  shift_reg <= next_shift;
                  bit_cnt <= bit_cnt + 3'h1;
                  state <= (last_bit || !act_master) ? SPS_IDLE : SPS_LOW;
               end
            end
            default: state <= SPS_IDLE;
         endcase
      end
   end

   // Pin drivers registered from the system clock; miso_out comes from the link side
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mosi_out <= 1'h0;
         mosi_oe <= 1'h0;
         sck_out <= 1'h0;
         sck_oe <= 1'h0;
         miso_oe <= 1'h0;
         slave_select_n_out <= 1'h1;
         slave_select_n_oe <= 1'h0;
         select_pin_mapped <= 1'h0;
      end else begin
         mosi_out <= shift_reg[`SPS_MSB];
         mosi_oe <= act_master;
         sck_out <= (state == SPS_HIGH);
         sck_oe <= act_master;
         miso_oe <= act_slave && selected;
         slave_select_n_out <= select_mode_field[`SPS_LO_BIT];
         slave_select_n_oe <= mode_out;
         select_pin_mapped <= !mode_3wire;
      end
   end

   // Link side, clocked by the external serial clock. Its reset holds the
   // bit count at zero while the port is off, while this end is master, or
   // while an unselected 4-wire slave sees the select pin high; releasing
   // that reset on the select fall restarts the count.
   wire link_reset = reset || !act_slave || (mode_4in && slave_select_n_in);

   always_ff @(posedge sck_in or posedge link_reset) begin
      if (link_reset) begin
         link_shift <= 8'h00;
         link_cnt <= 3'h0;
      end else begin
         // Byte start takes the holding word; tx_word is stable by then
         link_shift <= (link_cnt == 3'h0) ? {tx_word[`SPS_MSB-1:0], mosi_in}
                       : {link_shift[`SPS_MSB-1:0], mosi_in};
         link_cnt <= link_cnt + 3'h1;
      end
   end

   // Completed byte and toggle survive the link reset so no false event
   always_ff @(posedge sck_in or posedge reset) begin
      if (reset) begin
         link_hold <= 8'h00;
         link_tgl <= 1'h0;
      end else if (!link_reset && (link_cnt == `SPS_LAST_BIT)) begin
         link_hold <= {link_shift[`SPS_MSB-1:0], mosi_in};
         link_tgl <= ~link_tgl;
      end
   end

   // MISO: first bit from the holding word, then the shift MSB
   assign miso_out = (link_cnt == 3'h0) ? tx_word[`SPS_MSB] : link_shift[`SPS_MSB];

   // Received bytes; when full, a slave byte is lost as overrun
   sps_buffer u_rx_buffer (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(push_valid),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // Checks on the system clock
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_fault_cause;
      master_enable_bit && port_enable_bit && mode_4in && ss_s3 && !ss_s2;
   endsequence

   // One master bit is a low half then a high half of three clocks each
   sequence s_low_half;
      (state == SPS_LOW) [*3];
   endsequence
   sequence s_high_half;
      (state == SPS_HIGH) [*3];
   endsequence

   a_fault_drops_enables: assert property (
      s_fault_cause |=> !master_enable_bit && !port_enable_bit && mode_fault_flag)
      else $error("mode fault did not drop enables");
   a_fault_releases_pins: assert property (
      s_fault_cause |=> ##1 !sck_oe && !mosi_oe)
      else $error("master kept driving after mode fault");
   a_miso_floats_off: assert property (
      !port_enable_bit |=> !miso_oe)
      else $error("miso driven while port disabled");
   a_miso_unselected: assert property (
      (mode_4in && ss_s2) |=> !miso_oe)
      else $error("miso driven by unselected slave");
   a_sck_master_only: assert property (
      sck_oe |-> $past(act_master))
      else $error("sck driven while not master");
   a_mosi_dir_master: assert property (
      $rose(act_master) |=> mosi_oe && !miso_oe)
      else $error("mosi direction wrong for master");
   a_select_out_level: assert property (
      mode_out |=> slave_select_n_oe && (slave_select_n_out == $past(select_mode_field[0])))
      else $error("select output level mismatch");
   a_select_unmapped: assert property (
      mode_3wire |=> !select_pin_mapped && !slave_select_n_oe)
      else $error("select pin mapped in 3-wire mode");
   a_done_on_master: assert property (
      master_end |=> (transfer_done_flag && master_push) ##1 !master_push)
      else $error("done flag not set at byte end");
   a_byte_length: assert property (
      disable iff (reset || !act_master) start |=> s_low_half ##1 s_high_half)
      else $error("first master bit has wrong half lengths");
   // Eight bits of two three-clock halves end 48 clocks after the start
   a_byte_eight_bits: assert property (
      disable iff (reset || !act_master) start |-> ##48 master_end)
      else $error("master byte did not end after eight bits");
   a_slave_done_flag: assert property (
      (act_slave && slave_done) |=> transfer_done_flag)
      else $error("done flag not set at slave byte end");
   a_three_wire_drive: assert property (
      (act_slave && mode_3wire) |=> miso_oe)
      else $error("3-wire slave not driving miso");
   a_master_mosi_msb: assert property (
      act_master |=> mosi_oe && (mosi_out == $past(shift_reg[`SPS_MSB])))
      else $error("master mosi not from shift msb");
   a_fault_flag_holds: assert property (
      (mode_fault_flag && !clear_fault) |=> mode_fault_flag)
      else $error("fault flag lost without clear");
endmodule
